// ---- src/sel_latch_pkg.sv ----
package sel_latch_pkg;

  // APB geometry
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;

  // Register byte offsets
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_PORT_ADDR = 8'h04;
  localparam logic [7:0]  REG_BIT_SEL   = 8'h08;
  localparam logic [7:0]  REG_EXT_MATCH = 8'h0c;
  localparam logic [7:0]  REG_STATUS    = 8'h10;

  // Control fields
  localparam int          CTRL_WAIT_EN  = 0;
  localparam int          CTRL_EXT_MODE = 1;
  // Status fields
  localparam int          STAT_SEL      = 0;
  localparam int          STAT_WAIT     = 1;
  localparam int          STAT_BAD_SEL  = 2;

  // Reset values
  localparam logic [1:0]  CTRL_RST      = 2'h0;
  localparam logic [7:0]  PORT_ADDR_RST = 8'h40;
  localparam logic [7:0]  BIT_SEL_RST   = 8'h01;
  localparam logic [7:0]  EXT_MATCH_RST = 8'h00;
  localparam logic [7:0]  ONE8          = 8'h01;

  // Bus pins entering the block, sampled asynchronously
  typedef struct packed {
    logic       sout;       // Output status
    logic       pwr_n;      // Write strobe
    logic       reset_n;    // Bus reset
    logic       pdbin;      // Read strobe
    logic       mrq;        // Memory request
    logic       sxtrq_n;    // Sixteen-bit request
    logic       phantom_n;  // Phantom
    logic       sinta;      // Interrupt acknowledge
    logic       refresh;    // On-board refresh window
    logic [7:0] a_lo;       // Address 7..0
    logic [7:0] a_ext;      // Address 23..16
    logic [7:0] dout;       // Data out lines
  } pins_in_t;

  // Idle level of the pins, used as synchroniser reset value
  localparam pins_in_t PINS_IDLE = '{sout: 1'b0, pwr_n: 1'b1, reset_n: 1'b1,
    pdbin: 1'b0, mrq: 1'b0, sxtrq_n: 1'b1, phantom_n: 1'b1, sinta: 1'b0,
    refresh: 1'b0, a_lo: 8'h00, a_ext: 8'h00, dout: 8'h00};

  // Block outputs, all registered
  typedef struct packed {
    logic bank_decode_en;    // Bank decode enable
    logic select_indicator;  // Indicator lit
    logic read_en;           // Memory read enable
    logic write_en;          // Memory write enable
    logic prdy_o;            // Ready pin level
    logic prdy_oe_n;         // Ready pin driven when low
    logic sxtn_n_o;          // Extended ack level
    logic sxtn_oe_n;         // Extended ack driven when low
  } pins_out_t;

  localparam pins_out_t PINS_OUT_RST = '{bank_decode_en: 1'b0,
    select_indicator: 1'b0, read_en: 1'b0, write_en: 1'b0, prdy_o: 1'b0,
    prdy_oe_n: 1'b1, sxtn_n_o: 1'b0, sxtn_oe_n: 1'b1};

  // Switch-style address compare: a set bit matches one, clear matches zero
  function automatic logic addr_match(input logic [7:0] a, input logic [7:0] cfg);
    addr_match = (a == cfg);
  endfunction

endpackage

// ---- src/bus_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for a group of pins
module bus_sync #(
  parameter int           W  = 1,
  parameter logic [W-1:0] RV = '0
) (
  input  wire logic         clk,    // System clock
  input  wire logic         rst_n,  // Async reset, active low
  input  wire logic [W-1:0] d,      // Asynchronous pins
  output logic      [W-1:0] q       // Synchronised pins
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= RV;
      q      <= RV;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // bus_sync
`default_nettype wire

// ---- src/port_write_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port write decode: one pulse per write to the configured port
module port_write_decode (
  input  wire logic       clk,       // System clock
  input  wire logic       rst_n,     // Async reset, active low
  input  wire logic       sout,      // Output status, synced
  input  wire logic       pwr_n,     // Write strobe, synced
  input  wire logic [7:0] addr,      // Address 7..0, synced
  input  wire logic [7:0] port_addr, // Configured port address
  input  wire logic [7:0] data,      // Data byte, synced
  input  wire logic [7:0] bit_sel,   // One-hot data bit choice
  output logic            wr_pulse,  // One cycle per port write
  output logic            wr_value   // Value to load into the flag
);

  logic       buffered_write_strobe;
  logic       port_write_cycle;
  logic       hit;
  logic       hit_prev_r;
  logic [7:0] picked;

  // Cycle qualification and address compare
  assign buffered_write_strobe = ~pwr_n;
  assign port_write_cycle      = sout & buffered_write_strobe;
  assign hit = port_write_cycle & sel_latch_pkg::addr_match(addr, port_addr);

  // Gate each data bit with its chosen position
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pick
      assign picked[gi] = data[gi] & bit_sel[gi];
    end
  endgenerate

  // Rising edge of the hit gives exactly one pulse per write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hit_prev_r <= 1'b0;
      wr_pulse   <= 1'b0;
      wr_value   <= 1'b0;
    end
    else
    begin
      hit_prev_r <= hit;
      wr_pulse   <= hit & ~hit_prev_r;
      wr_value   <= |picked;
    end
  end

endmodule // port_write_decode
`default_nettype wire

// ---- src/io_port_board_select_latch.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Port write needs output status and strobe
// - Compare low address byte to port
// - Set bit matches one, clear matches zero
// - Outside bus reset and extended mode, clock the flag only on port writes
// - On that pulse, flag takes decoded value
// - Chosen data bit high selects board
// - Zero or unchosen ones deselect board
// - Bus reset with bit0 high selects
// - Bus reset with bit0 low deselects
// - Bit0 ignored while bus reset idle
// - Selected lights indicator, enables bank decode
// - Read and write enables need selection
// - Ready pull-down needs selection
// - Wait option holds ready low during refresh
// - Only ready and extended ack driven
// - Extended address may select instead
module io_port_board_select_latch (
  input  wire logic                            pclk,     // 50 MHz clock
  input  wire logic                            presetn,  // Async reset, low
  input  wire logic                            psel,     // APB select
  input  wire logic                            penable,  // APB enable
  input  wire logic                            pwrite,   // APB write
  input  wire logic [sel_latch_pkg::ADDR_W-1:0] paddr,   // APB byte address
  input  wire logic [sel_latch_pkg::DATA_W-1:0] pwdata,  // APB write data
  output logic      [sel_latch_pkg::DATA_W-1:0] prdata,  // APB read data
  output logic                                 pready,   // APB ready
  output logic                                 pslverr,  // APB error
  input  wire sel_latch_pkg::pins_in_t         pins_i,   // Bus pins in
  output sel_latch_pkg::pins_out_t             pins_o    // Bus pins out
);

  // Synchronised pins
  sel_latch_pkg::pins_in_t pin_s;

  // Configuration
  logic [1:0] ctrl_r;
  logic [7:0] port_addr_r;
  logic [7:0] bit_sel_r;
  logic [7:0] ext_match_r;

  // Select state
  logic board_selected_flag;
  logic sel_nxt;
  logic wr_pulse;
  logic wr_value;
  logic buffered_bus_reset;
  logic wait_en;
  logic ext_mode;
  logic wait_active;
  logic bit_sel_bad;

  // APB
  logic                              acc;
  logic                              fire;
  logic                              mapped;
  logic [sel_latch_pkg::DATA_W-1:0]  rd_nxt;
  logic                              pready_r;
  sel_latch_pkg::pins_out_t          out_nxt;

  // Every pin crosses two flops before use
  bus_sync #(
    .W  ($bits(sel_latch_pkg::pins_in_t)),
    .RV (sel_latch_pkg::PINS_IDLE)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (pins_i),
    .q     (pin_s)
  );

  // Port write decode and data bit pick
  port_write_decode u_dec (
    .clk       (pclk),
    .rst_n     (presetn),
    .sout      (pin_s.sout),
    .pwr_n     (pin_s.pwr_n),
    .addr      (pin_s.a_lo),
    .port_addr (port_addr_r),
    .data      (pin_s.dout),
    .bit_sel   (bit_sel_r),
    .wr_pulse  (wr_pulse),
    .wr_value  (wr_value)
  );

  // Control decode
  assign buffered_bus_reset = ~pin_s.reset_n;
  assign wait_en  = ctrl_r[sel_latch_pkg::CTRL_WAIT_EN];
  assign ext_mode = ctrl_r[sel_latch_pkg::CTRL_EXT_MODE];
  assign bit_sel_bad = (bit_sel_r == 8'h00) ||
                       ((bit_sel_r & (bit_sel_r - sel_latch_pkg::ONE8)) != 8'h00);
  assign wait_active = board_selected_flag & wait_en & pin_s.refresh;

  // Next select state: bus reset first, then the chosen selection method
  always_comb
  begin
    sel_nxt = board_selected_flag;
    if (buffered_bus_reset)
    begin
      sel_nxt = pin_s.dout[0];
    end
    else if (ext_mode)
    begin
      sel_nxt = sel_latch_pkg::addr_match(pin_s.a_ext, ext_match_r);
    end
    else if (wr_pulse)
    begin
      sel_nxt = wr_value;
    end
  end

  // Select flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      board_selected_flag <= 1'b0;
    end
    else
    begin
      board_selected_flag <= sel_nxt;
    end
  end

  // Bus-side outputs, all qualified by the select flag
  always_comb
  begin
    out_nxt                  = sel_latch_pkg::PINS_OUT_RST;
    out_nxt.bank_decode_en   = board_selected_flag;
    out_nxt.select_indicator = board_selected_flag;
    out_nxt.read_en   = board_selected_flag & pin_s.pdbin &
                        pin_s.phantom_n & ~pin_s.sinta;
    out_nxt.write_en  = board_selected_flag & ~pin_s.pwr_n & pin_s.mrq;
    out_nxt.prdy_oe_n = ~wait_active;
    out_nxt.sxtn_oe_n = ~(board_selected_flag & ~pin_s.sxtrq_n & pin_s.mrq);
  end

  // Output register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pins_o <= sel_latch_pkg::PINS_OUT_RST;
    end
    else
    begin
      pins_o <= out_nxt;
    end
  end

  // APB handshake: one wait state, transfer done at the pready edge
  assign acc    = psel & penable;
  assign fire   = acc & pready_r;
  assign pready = pready_r;
  assign mapped = (paddr == sel_latch_pkg::REG_CTRL) ||
                  (paddr == sel_latch_pkg::REG_PORT_ADDR) ||
                  (paddr == sel_latch_pkg::REG_BIT_SEL) ||
                  (paddr == sel_latch_pkg::REG_EXT_MATCH) ||
                  (paddr == sel_latch_pkg::REG_STATUS);

  // Read mux; unmapped reads return zero
  always_comb
  begin
    rd_nxt = '0;
    case (paddr)
      sel_latch_pkg::REG_CTRL:      rd_nxt[1:0] = ctrl_r;
      sel_latch_pkg::REG_PORT_ADDR: rd_nxt[7:0] = port_addr_r;
      sel_latch_pkg::REG_BIT_SEL:   rd_nxt[7:0] = bit_sel_r;
      sel_latch_pkg::REG_EXT_MATCH: rd_nxt[7:0] = ext_match_r;
      sel_latch_pkg::REG_STATUS:
      begin
        rd_nxt[sel_latch_pkg::STAT_SEL]     = board_selected_flag;
        rd_nxt[sel_latch_pkg::STAT_WAIT]    = wait_active;
        rd_nxt[sel_latch_pkg::STAT_BAD_SEL] = bit_sel_bad;
      end
      default:                      rd_nxt = '0;
    endcase
  end

  // Ready: high for the second access cycle only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
    end
    else
    begin
      pready_r <= acc & ~pready_r;
    end
  end

  // Read data: captured in the wait cycle, stands until the next transfer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
    end
    else if (acc & ~pready_r)
    begin
      prdata <= pwrite ? '0 : rd_nxt;
    end
  end

  // Error: raised together with ready for an unmapped address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= acc & ~pready_r & ~mapped;
    end
  end

  // Write strobe for one register offset; status has no write path
  function automatic logic reg_wr(input logic       wr_ok,
                                  input logic [7:0] a,
                                  input logic [7:0] off);
    reg_wr = wr_ok & (a == off);
  endfunction

  // Control: wait option and extended selection mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= sel_latch_pkg::CTRL_RST;
    end
    else if (reg_wr(fire & pwrite, paddr, sel_latch_pkg::REG_CTRL))
    begin
      ctrl_r <= pwdata[1:0];
    end
  end

  // Port address compare pattern
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_addr_r <= sel_latch_pkg::PORT_ADDR_RST;
    end
    else if (reg_wr(fire & pwrite, paddr, sel_latch_pkg::REG_PORT_ADDR))
    begin
      port_addr_r <= pwdata[7:0];
    end
  end

  // Data bit choice; several bits are ORed and flagged in status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_sel_r <= sel_latch_pkg::BIT_SEL_RST;
    end
    else if (reg_wr(fire & pwrite, paddr, sel_latch_pkg::REG_BIT_SEL))
    begin
      bit_sel_r <= pwdata[7:0];
    end
  end

  // Extended address compare value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_match_r <= sel_latch_pkg::EXT_MATCH_RST;
    end
    else if (reg_wr(fire & pwrite, paddr, sel_latch_pkg::REG_EXT_MATCH))
    begin
      ext_match_r <= pwdata[7:0];
    end
  end

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_apb_setup;
    psel && !penable;
  endsequence

  sequence s_apb_access;
    psel && penable && !pready;
  endsequence

  a_apb_one_wait: assert property (s_apb_setup ##1 s_apb_access |=> pready)
    else $error("APB ready not given one cycle into access");

  a_pulse_cause: assert property (wr_pulse |-> $past(pin_s.sout && !pin_s.pwr_n &&
    pin_s.a_lo == port_addr_r))
    else $error("Port write pulse without a matching port write");

  a_pulse_once: assert property (wr_pulse |=> !wr_pulse)
    else $error("Port write pulse longer than one cycle");

  a_capture_val: assert property (!buffered_bus_reset && !ext_mode && wr_pulse
    |=> board_selected_flag == $past(wr_value))
    else $error("Select flag did not take the written value");

  a_hold_idle: assert property (!buffered_bus_reset && !ext_mode && !wr_pulse
    |=> $stable(board_selected_flag))
    else $error("Select flag changed without a port write");

  a_reset_set: assert property (buffered_bus_reset && pin_s.dout[0]
    |=> board_selected_flag)
    else $error("Bus reset with bit 0 high did not select");

  a_reset_clear: assert property (buffered_bus_reset && !pin_s.dout[0]
    |=> !board_selected_flag)
    else $error("Bus reset with bit 0 low did not deselect");

  a_indicator_follow: assert property (##1 pins_o.select_indicator ==
    $past(board_selected_flag) && pins_o.bank_decode_en == pins_o.select_indicator)
    else $error("Indicator or bank decode not following select flag");

  a_enables_qualified: assert property (pins_o.read_en || pins_o.write_en
    |-> $past(board_selected_flag))
    else $error("Memory enable while deselected");

  a_ready_needs_sel: assert property (!pins_o.prdy_oe_n
    |-> $past(board_selected_flag) && !pins_o.prdy_o)
    else $error("Ready pulled low while deselected");

  a_ready_wait: assert property (board_selected_flag && wait_en && pin_s.refresh
    |=> !pins_o.prdy_oe_n)
    else $error("Ready not pulled low during refresh window");

  a_pulse_follows: assert property ($rose(pin_s.sout && !pin_s.pwr_n &&
    pin_s.a_lo == port_addr_r) |=> wr_pulse)
    else $error("Port write gave no clock pulse");

  a_zero_write: assert property (!buffered_bus_reset && !ext_mode && wr_pulse &&
    !wr_value |=> !board_selected_flag)
    else $error("Write without a chosen one bit did not deselect");

  a_ext_select: assert property (!buffered_bus_reset && ext_mode
    |=> board_selected_flag == $past(pin_s.a_ext == ext_match_r))
    else $error("Extended address compare not followed");

endmodule // io_port_board_select_latch
`default_nettype wire

// ---- tb/s100_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Bus master on the far side of the block: drives every bus pin it owns
module s100_master_model (
  input  wire logic               clk,   // System clock
  output var sel_latch_pkg::pins_in_t pins // Bus pins towards the block
);
  // Bus idle at time zero
  initial pins = sel_latch_pkg::PINS_IDLE;

  // Whole pin set changes just after a rising edge
  task automatic apply(input sel_latch_pkg::pins_in_t p);
    @(posedge clk);
    pins <= p;
  endtask

  // Port output cycle; strobe, status, address and data held together
  task automatic port_write(input logic [7:0] a, input logic [7:0] d, input logic s);
    sel_latch_pkg::pins_in_t p;
    p = pins;
    p.sout = s;
    p.pwr_n = 1'b0;
    p.a_lo = a;
    p.dout = d;
    apply(p);
    repeat (4) @(posedge clk);
    // Released lines must not keep showing the last value
    p.sout = 1'b0;
    p.pwr_n = 1'b1;
    p.a_lo = ~a;
    p.dout = ~d;
    apply(p);
    repeat (8) @(posedge clk);
  endtask

  // Bus reset with a chosen level on data bit 0, then data bit 0 flips
  task automatic bus_reset(input logic b0);
    sel_latch_pkg::pins_in_t p;
    p = pins;
    p.reset_n = 1'b0;
    p.dout[0] = b0;
    apply(p);
    repeat (8) @(posedge clk);
    p.reset_n = 1'b1;
    p.dout = ~p.dout;
    apply(p);
    repeat (8) @(posedge clk);
  endtask
endmodule // s100_master_model
`default_nettype wire

// ---- tb/tb_io_port_board_select_latch.sv ----
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the board select latch
module tb_io_port_board_select_latch;
  typedef struct packed {
    logic [7:0] port;
    logic [7:0] bsel;
    logic [7:0] addr;
    logic       sout;
    logic [7:0] data;
    logic       sel;
  } row_t;

  logic                             pclk;
  logic                             presetn;
  logic                             psel;
  logic                             penable;
  logic                             pwrite;
  logic [sel_latch_pkg::ADDR_W-1:0] paddr;
  logic [sel_latch_pkg::DATA_W-1:0] pwdata;
  logic [sel_latch_pkg::DATA_W-1:0] prdata;
  logic                             pready;
  logic                             pslverr;
  sel_latch_pkg::pins_in_t          pins_i;
  sel_latch_pkg::pins_out_t         pins_o;
  sel_latch_pkg::pins_in_t          v;
  logic [31:0]                      q;
  logic                             e;
  int                               num_errors = 0;
  int                               n_compared = 0;
  // Port, bit choice, cycle address, status, data, expected selection
  row_t rows [9] = '{'{8'h40, 8'h01, 8'h40, 1'b1, 8'h01, 1'b1},
                     '{8'h40, 8'h01, 8'h40, 1'b1, 8'h00, 1'b0},
                     '{8'h40, 8'h01, 8'h41, 1'b1, 8'h01, 1'b0},
                     '{8'h40, 8'h01, 8'h40, 1'b0, 8'h01, 1'b0},
                     '{8'hff, 8'h80, 8'hff, 1'b1, 8'h80, 1'b1},
                     '{8'hff, 8'h80, 8'hff, 1'b1, 8'h7f, 1'b0},
                     '{8'h00, 8'h08, 8'h00, 1'b1, 8'h08, 1'b1},
                     '{8'h00, 8'h08, 8'h80, 1'b1, 8'h00, 1'b1},
                     '{8'ha5, 8'h04, 8'ha5, 1'b1, 8'hfb, 1'b0}};

  io_port_board_select_latch dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_i(pins_i),
    .pins_o(pins_o));

  s100_master_model m (.clk(pclk), .pins(pins_i));

  // Clock, 20 ns period
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    finish_test();
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask

  // Indicator and bank decode both follow the flag
  task automatic sel_is(input logic s);
    chk({pins_o.select_indicator, pins_o.bank_decode_en}, {s, s});
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(sel_latch_pkg::REG_CTRL, 32'h0);
    rd(sel_latch_pkg::REG_PORT_ADDR, 32'h40);
    rd(sel_latch_pkg::REG_BIT_SEL, 32'h01);
    rd(sel_latch_pkg::REG_EXT_MATCH, 32'h0);
    rd(sel_latch_pkg::REG_STATUS, 32'h0);
    chk(pins_o, sel_latch_pkg::PINS_OUT_RST);
    wr(8'h14, 32'hffff_ffff);
    chk(e, 1'b1);
    rd(8'h14, 32'h0);
    chk(e, 1'b1);
    // Table of port writes
    foreach (rows[i])
    begin
      wr(sel_latch_pkg::REG_PORT_ADDR, {24'h0, rows[i].port});
      wr(sel_latch_pkg::REG_BIT_SEL, {24'h0, rows[i].bsel});
      m.port_write(rows[i].addr, rows[i].data, rows[i].sout);
      sel_is(rows[i].sel);
      rd(sel_latch_pkg::REG_STATUS, {31'h0, rows[i].sel});
    end
    // Two bit choices at once: chosen ones are ORed and flagged
    wr(sel_latch_pkg::REG_BIT_SEL, 32'h03);
    m.port_write(8'ha5, 8'h02, 1'b1);
    rd(sel_latch_pkg::REG_STATUS, 32'h5);
    // Bus reset both ways, then enables, wait and extended ack
    for (int s = 1; s >= 0; s--)
    begin
      m.bus_reset(s[0]);
      sel_is(s[0]);
      wr(sel_latch_pkg::REG_CTRL, 32'h1);
      v = m.pins;
      v.pdbin = 1'b1;
      v.mrq = 1'b1;
      v.pwr_n = 1'b0;
      v.sxtrq_n = 1'b0;
      v.refresh = 1'b1;
      m.apply(v);
      repeat (6) @(posedge pclk);
      chk({pins_o.read_en, pins_o.write_en, pins_o.sxtn_oe_n, pins_o.prdy_oe_n},
          {s[0], s[0], !s[0], !s[0]});
      rd(sel_latch_pkg::REG_STATUS, {29'h0, 1'b1, s[0], s[0]});
      m.apply(sel_latch_pkg::PINS_IDLE);
      repeat (6) @(posedge pclk);
      chk(pins_o.prdy_oe_n, 1'b1);
    end
    // Extended address selection
    wr(sel_latch_pkg::REG_EXT_MATCH, 32'h3c);
    wr(sel_latch_pkg::REG_CTRL, 32'h2);
    v = m.pins;
    v.a_ext = 8'h3c;
    m.apply(v);
    repeat (6) @(posedge pclk);
    sel_is(1'b1);
    v.a_ext = 8'h3d;
    m.apply(v);
    repeat (6) @(posedge pclk);
    sel_is(1'b0);
    // Mid-run reset while selected: flag, control and port address registers and pins back to reset
    v.a_ext = 8'h3c;
    m.apply(v);
    repeat (6) @(posedge pclk);
    sel_is(1'b1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(sel_latch_pkg::REG_CTRL, {30'h0, sel_latch_pkg::CTRL_RST});
    rd(sel_latch_pkg::REG_PORT_ADDR, {24'h0, sel_latch_pkg::PORT_ADDR_RST});
    rd(sel_latch_pkg::REG_STATUS, 32'h0);
    chk(pins_o, sel_latch_pkg::PINS_OUT_RST);
    finish_test();
  end
endmodule // tb_io_port_board_select_latch
`default_nettype wire
